//--- shared/btzm_pkg.sv
`default_nettype none
package btzm_pkg;
   // charge voltage code step is 25mV per lsb; 200mV margin is 8 codes
   localparam int unsigned CV_STEP_MV = 25;
   localparam int unsigned RAIL_MARGIN_MV = 200;
   localparam logic [5:0] RAIL_MARGIN_CODES = 6'(RAIL_MARGIN_MV / CV_STEP_MV);
   // temperature zone codes reported in the status field
   localparam logic [2:0] ZONE_OFF = 3'h0;
   localparam logic [2:0] ZONE_COLD = 3'h1;
   localparam logic [2:0] ZONE_COOL = 3'h2;
   localparam logic [2:0] ZONE_WARM = 3'h3;
   localparam logic [2:0] ZONE_HOT = 3'h4;
   localparam logic [2:0] ZONE_NORMAL = 3'h5;
   // analog monitor selections that touch the thermistor network
   localparam logic [3:0] MUX_SEL_NTC_SENSE = 4'h7;
   localparam logic [3:0] MUX_SEL_NTC_BIAS = 4'h8;
   // reset values
   localparam logic [2:0] ZONE_RESET = 3'h0;
   localparam logic [5:0] CV_RESET = 6'h00;
   localparam logic [2:0] RESUME_RESET = 3'h0; // saved charger state before any fault
   // charge states, one-hot
   typedef enum logic [2:0] {
      BTZM_NORMAL = 3'b001,
      BTZM_MODIFIED = 3'b010,
      BTZM_TEMP_FAULT = 3'b100
   } btzm_zone_state_t;
endpackage : btzm_pkg
`default_nettype wire

//--- rtl/btzm_monitor.sv
// Overview of operation
// - device lowers charge voltage code on violation
// - override raises rail configuration error flag
// - enabled monitor evaluates sense against thresholds continuously
// - normal zone uses normal voltage and current
// - warm or cool zones use modified codes
// - hot or cold zones force temperature fault
// - three-bit zone status readable by software
// - zone status change sets maskable flag
// - monitor disabled removes every temperature response
// - each threshold chosen by own two-bit field
// - bias on with valid input and enable
// - bias on when monitor mux selects ntc
// - mux selection never affects temperature response
// - temperature fault wins, exit returns prior state
// - fault pauses timers; fast and topoff restart
`timescale 1ns/10ps
`default_nettype none
module btzm_monitor (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ntc_monitor_enable, // config bit
   input wire logic charge_input_valid, // input source valid
   input wire logic [3:0] analog_monitor_select, // monitor mux channel
   input wire logic [1:0] hot_trip_select,
   input wire logic [1:0] warm_trip_select,
   input wire logic [1:0] cool_trip_select,
   input wire logic [1:0] cold_trip_select,
   // comparator results: sense pin below (hot, warm) or above (cool, cold) each of the four trip voltages per bank
   input wire logic [3:0] sense_below_hot_trip,
   input wire logic [3:0] sense_below_warm_trip,
   input wire logic [3:0] sense_above_cool_trip,
   input wire logic [3:0] sense_above_cold_trip,
   input wire logic [5:0] charge_voltage_request, // software written code
   input wire logic [5:0] rail_target_code, // rail target in same code scale
   input wire logic [5:0] modified_voltage_code,
   input wire logic [5:0] modified_current_code,
   input wire logic [5:0] normal_current_code,
   input wire logic rail_irq_clear, // software clear pulse
   input wire logic zone_irq_clear,
   input wire logic zone_irq_mask, // high masks the change flag
   input wire logic [2:0] charger_prior_state, // state machine state to save
   output logic [5:0] charge_voltage_code, // effective code after guard
   output logic [5:0] active_voltage_code,
   output logic [5:0] active_current_code,
   output logic charging_allowed,
   output logic temp_fault,
   output logic [2:0] resume_state, // state to return to after fault
   output logic fast_timer_restart, // pulse on fault exit
   output logic topoff_timer_restart, // pulse on fault exit
   output logic timers_paused,
   output logic [2:0] temp_zone_status,
   output logic rail_config_error_irq,
   output logic temp_zone_change_irq,
   output logic ntc_bias_output
);
   // registers
   logic [5:0] cv_q;
   logic rail_irq_q;
   logic [2:0] zone_q;
   logic zone_irq_q;
   btzm_pkg::btzm_zone_state_t state_q;
   btzm_pkg::btzm_zone_state_t state_d;
   logic [2:0] saved_q;
   logic restart_q;
   logic [5:0] cv_d;
   logic [6:0] cv_ceiling;
   logic over_margin;
   logic hot, warm, cool, cold;
   logic [2:0] zone_d;

   // margin check: ceiling is rail minus the margin, floored at zero
   always_comb begin
      cv_ceiling = {1'b0, rail_target_code} - {1'b0, btzm_pkg::RAIL_MARGIN_CODES};
      over_margin = cv_ceiling[6] || (charge_voltage_request > cv_ceiling[5:0]);
      if (!over_margin) begin
         cv_d = charge_voltage_request;
      end else if (cv_ceiling[6]) begin
         cv_d = 6'h00; // rail too low for any code
      end else begin
         cv_d = cv_ceiling[5:0];
      end
   end

   // effective charge voltage code is registered
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cv_q <= btzm_pkg::CV_RESET;
      end else begin
         cv_q <= cv_d;
      end
   end

   // sticky config error flag, set beats clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rail_irq_q <= 1'b0;
      end else if (over_margin) begin
         rail_irq_q <= 1'b1;
      end else if (rail_irq_clear) begin
         rail_irq_q <= 1'b0;
      end
   end

   // threshold selection; mux channel is not an input here, so it cannot disturb it
   always_comb begin
      hot = sense_below_hot_trip[hot_trip_select];
      warm = sense_below_warm_trip[warm_trip_select];
      cool = !sense_above_cool_trip[cool_trip_select];
      cold = !sense_above_cold_trip[cold_trip_select];
      if (!ntc_monitor_enable) begin
         zone_d = btzm_pkg::ZONE_OFF;
      end else if (hot) begin
         zone_d = btzm_pkg::ZONE_HOT;
      end else if (cold) begin
         zone_d = btzm_pkg::ZONE_COLD;
      end else if (warm) begin
         zone_d = btzm_pkg::ZONE_WARM;
      end else if (cool) begin
         zone_d = btzm_pkg::ZONE_COOL;
      end else begin
         zone_d = btzm_pkg::ZONE_NORMAL;
      end
   end

   // zone status register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         zone_q <= btzm_pkg::ZONE_RESET;
      end else begin
         zone_q <= zone_d;
      end
   end

   // change flag; a change in the clear cycle still sets it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         zone_irq_q <= 1'b0;
      end else if (zone_d != zone_q) begin
         zone_irq_q <= 1'b1;
      end else if (zone_irq_clear) begin
         zone_irq_q <= 1'b0;
      end
   end

   // next charge state from registered zone
   always_comb begin
      unique case (zone_q)
         btzm_pkg::ZONE_HOT, btzm_pkg::ZONE_COLD: begin
            state_d = btzm_pkg::BTZM_TEMP_FAULT;
         end
         btzm_pkg::ZONE_WARM, btzm_pkg::ZONE_COOL: begin
            state_d = btzm_pkg::BTZM_MODIFIED;
         end
         // off and normal land here, as would the unused codes 6 and 7
         default: begin
            state_d = btzm_pkg::BTZM_NORMAL;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= btzm_pkg::BTZM_NORMAL; // charging allowed out of reset
      end else begin
         state_q <= state_d;
      end
   end

   // remember charger state on fault entry so exit returns there
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         saved_q <= btzm_pkg::RESUME_RESET;
      end else if (state_d == btzm_pkg::BTZM_TEMP_FAULT
                   && state_q != btzm_pkg::BTZM_TEMP_FAULT) begin
         // captured once on entry; a prior state that moves during the fault is ignored
         saved_q <= charger_prior_state;
      end
   end

   // one pulse on fault exit restarts fast and topoff timers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         restart_q <= 1'b0;
      end else begin
         // high in the first cycle out of the fault, alongside the fall of temp_fault
         restart_q <= (state_q == btzm_pkg::BTZM_TEMP_FAULT)
            && (state_d != btzm_pkg::BTZM_TEMP_FAULT);
      end
   end

   // outputs; fault overrides every other charge decision
   always_comb begin
      temp_fault = (state_q == btzm_pkg::BTZM_TEMP_FAULT);
      charging_allowed = !temp_fault;
      // prequalification timer resumes simply by this level dropping
      timers_paused = temp_fault;
      // modified codes only in the modified state; a faulted charger keeps the normal ones
      active_voltage_code = (state_q == btzm_pkg::BTZM_MODIFIED) ? modified_voltage_code
                                                                 : cv_q;
      active_current_code = (state_q == btzm_pkg::BTZM_MODIFIED) ? modified_current_code
                                                       : normal_current_code;
   end

   assign charge_voltage_code = cv_q;
   assign resume_state = saved_q;
   assign fast_timer_restart = restart_q;
   assign topoff_timer_restart = restart_q;
   assign temp_zone_status = zone_q;
   assign rail_config_error_irq = rail_irq_q;
   assign temp_zone_change_irq = zone_irq_q && !zone_irq_mask;
   // bias: either condition turns it on, neither leaves it off
   assign ntc_bias_output = (charge_input_valid && ntc_monitor_enable)
      || (analog_monitor_select == btzm_pkg::MUX_SEL_NTC_SENSE)
      || (analog_monitor_select == btzm_pkg::MUX_SEL_NTC_BIAS);

   // fault entry and exit, each seen over two sampling edges
   sequence s_fault_entry;
      (state_q != btzm_pkg::BTZM_TEMP_FAULT) ##1 (state_q == btzm_pkg::BTZM_TEMP_FAULT);
   endsequence

   sequence s_fault_exit;
      (state_q == btzm_pkg::BTZM_TEMP_FAULT) ##1 (state_q != btzm_pkg::BTZM_TEMP_FAULT);
   endsequence

   // monitor held off for two edges, long enough to flush zone and state
   sequence s_held_off;
      (!ntc_monitor_enable) [*2];
   endsequence

   // rail guard: a violation lowers the code and raises the flag on the next edge;
   // when the rail sits below the margin itself the code bottoms out at zero
   AST_MARGIN: assert property (@(posedge clk) disable iff (!rst_n)
      over_margin |=> rail_config_error_irq
         && charge_voltage_code <= $past(charge_voltage_request)
         && (charge_voltage_code == 6'h00 || {1'b0, charge_voltage_code}
            + {1'b0, btzm_pkg::RAIL_MARGIN_CODES} <= {1'b0, $past(rail_target_code)}))
      else $error("margin violation not handled");
   AST_CV_PASS: assert property (@(posedge clk) disable iff (!rst_n)
      !over_margin |=> charge_voltage_code == $past(charge_voltage_request))
      else $error("legal code was altered");
   AST_RAIL_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
      over_margin |=> rail_irq_q) else $error("config flag not set");
   AST_RAIL_IRQ_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
      rail_config_error_irq && !rail_irq_clear |=> rail_config_error_irq)
      else $error("config flag dropped without a clear");

   // zone register follows the selected comparators on the next edge
   AST_ZONE_HOT_TRACK: assert property (@(posedge clk) disable iff (!rst_n)
      ntc_monitor_enable && sense_below_hot_trip[hot_trip_select]
         |=> temp_zone_status == btzm_pkg::ZONE_HOT)
      else $error("hot comparator not reported");
   AST_ZONE_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      !ntc_monitor_enable |=> temp_zone_status == btzm_pkg::ZONE_OFF)
      else $error("zone not off when disabled");
   AST_DISABLED_NO_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
      s_held_off |=> !temp_fault && active_current_code == normal_current_code)
      else $error("temperature response while disabled");
   AST_ZONE_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
      (temp_zone_status != $past(temp_zone_status)) |-> zone_irq_q)
      else $error("zone change flag missing");
   AST_ZONE_MASK: assert property (@(posedge clk) disable iff (!rst_n)
      zone_irq_mask |-> !temp_zone_change_irq) else $error("masked zone flag visible");

   // charge state follows the zone register one edge later
   AST_HOT_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
      (temp_zone_status == btzm_pkg::ZONE_HOT) |=> temp_fault && !charging_allowed)
      else $error("hot zone did not fault");
   AST_COLD_FAULT: assert property (@(posedge clk) disable iff (!rst_n)
      (temp_zone_status == btzm_pkg::ZONE_COLD) |=> temp_fault && !charging_allowed)
      else $error("cold zone did not fault");
   AST_MODIFIED: assert property (@(posedge clk) disable iff (!rst_n)
      (temp_zone_status == btzm_pkg::ZONE_WARM) |=> active_voltage_code == modified_voltage_code)
      else $error("warm zone not modified");
   AST_COOL_MODIFIED: assert property (@(posedge clk) disable iff (!rst_n)
      (temp_zone_status == btzm_pkg::ZONE_COOL) |=> active_current_code == modified_current_code)
      else $error("cool zone not modified");
   AST_NORMAL: assert property (@(posedge clk) disable iff (!rst_n)
      (temp_zone_status == btzm_pkg::ZONE_NORMAL) |=> !temp_fault
         && active_current_code == normal_current_code)
      else $error("normal zone altered");

   // fault bookkeeping: saved state, paused timers, restart pulse on the way out
   AST_RESUME: assert property (@(posedge clk) disable iff (!rst_n)
      s_fault_entry |-> resume_state == $past(charger_prior_state))
      else $error("prior state not kept on fault entry");
   AST_RESUME_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      temp_fault && $past(temp_fault) |-> $stable(resume_state))
      else $error("saved state moved during fault");
   AST_PAUSE: assert property (@(posedge clk) disable iff (!rst_n)
      temp_fault |-> timers_paused && !fast_timer_restart && !topoff_timer_restart)
      else $error("timers not held during fault");
   AST_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
      s_fault_exit |-> fast_timer_restart && topoff_timer_restart)
      else $error("timers not restarted on exit");

   // bias source: on for either reason, off for neither
   AST_BIAS: assert property (@(posedge clk) disable iff (!rst_n)
      (charge_input_valid && ntc_monitor_enable) |-> ntc_bias_output)
      else $error("bias off while enabled");
   AST_BIAS_MUX: assert property (@(posedge clk) disable iff (!rst_n)
      (analog_monitor_select == btzm_pkg::MUX_SEL_NTC_SENSE
         || analog_monitor_select == btzm_pkg::MUX_SEL_NTC_BIAS) |-> ntc_bias_output)
      else $error("bias off while mux reads the ntc");
   AST_BIAS_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      !(charge_input_valid && ntc_monitor_enable)
         && analog_monitor_select != btzm_pkg::MUX_SEL_NTC_SENSE
         && analog_monitor_select != btzm_pkg::MUX_SEL_NTC_BIAS |-> !ntc_bias_output)
      else $error("bias on with no reason");
endmodule : btzm_monitor
`default_nettype wire

//--- verif/btzm_ntc_model.sv
`timescale 1ns/10ps
`default_nettype none
// thermistor divider and comparator banks; temperature in plain steps
module btzm_ntc_model (
   input wire logic [7:0] battery_temp,
   input wire logic bias_on,
   output logic [3:0] below_hot,
   output logic [3:0] below_warm,
   output logic [3:0] above_cool,
   output logic [3:0] above_cold
);
   // trip i sits four steps past trip i-1; an unbiased node reads junk, not zone
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         below_hot[i] = bias_on ? int'(battery_temp) > 100 + 4 * i : i[0];
         below_warm[i] = bias_on ? int'(battery_temp) > 80 + 4 * i : !i[0];
         above_cool[i] = bias_on ? int'(battery_temp) > 40 + 4 * i : i[0];
         above_cold[i] = bias_on ? int'(battery_temp) > 20 + 4 * i : !i[0];
      end
   end
endmodule : btzm_ntc_model
`default_nettype wire

//--- verif/btzm_monitor_test.sv
`timescale 1ns/10ps
`default_nettype none
module btzm_monitor_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic en = 1'b1, vld = 1'b1, rclr = 1'b0, zclr = 1'b0, zmask = 1'b0, rexp = 1'b0;
   logic [3:0] mux = 4'h0;
   logic [1:0] hs = 2'h2, ws = 2'h2, cs = 2'h2, ds = 2'h2;
   logic [5:0] req = 6'h14, rail = 6'h28, mv = 6'h0a, mc = 6'h05, nc = 6'h1e, cve = 6'h14;
   logic [2:0] prior = 3'h6, pz = 3'h0, rs, zs;
   logic [7:0] temp = 8'h3c;
   logic [7:0] zt [7] = '{8'h3c, 8'h5a, 8'h6e, 8'h3c, 8'h1e, 8'h0a, 8'h3c};
   logic [3:0] mt [4] = '{4'h0, 4'h7, 4'h8, 4'h9};
   logic [3:0] bh, bw, ac, ad;
   logic [5:0] cv, av, aic;
   logic ok, tf, fr, tr, tp, rirq, zirq, bias, be;
   int errors = 0;
   int total_checks = 0;
   btzm_ntc_model ntc (.battery_temp(temp), .bias_on(bias), .below_hot(bh), .below_warm(bw),
      .above_cool(ac), .above_cold(ad));
   btzm_monitor DUT (.clk(clk), .rst_n(rst_n), .ntc_monitor_enable(en), .charge_input_valid(vld),
      .analog_monitor_select(mux), .hot_trip_select(hs), .warm_trip_select(ws),
      .cool_trip_select(cs), .cold_trip_select(ds), .sense_below_hot_trip(bh),
      .sense_below_warm_trip(bw), .sense_above_cool_trip(ac), .sense_above_cold_trip(ad),
      .charge_voltage_request(req), .rail_target_code(rail), .modified_voltage_code(mv),
      .modified_current_code(mc), .normal_current_code(nc), .rail_irq_clear(rclr),
      .zone_irq_clear(zclr), .zone_irq_mask(zmask), .charger_prior_state(prior),
      .charge_voltage_code(cv), .active_voltage_code(av), .active_current_code(aic),
      .charging_allowed(ok), .temp_fault(tf), .resume_state(rs), .fast_timer_restart(fr),
      .topoff_timer_restart(tr), .timers_paused(tp), .temp_zone_status(zs),
      .rail_config_error_irq(rirq), .temp_zone_change_irq(zirq), .ntc_bias_output(bias));
   // 5 ns period
   always #2.5 clk = ~clk;
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s expected %0h seen %0h", n, e, s);
      end
   endtask : chk
   // inputs move on the falling edge only
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   // zone from the same trip spacing as the model; hot/cold win over warm/cool
   function automatic logic [2:0] ez(input logic [7:0] t);
      if (!en) return btzm_pkg::ZONE_OFF;
      if (t > 8'h64 + 8'({hs, 2'h0})) return btzm_pkg::ZONE_HOT;
      if (t <= 8'h14 + 8'({ds, 2'h0})) return btzm_pkg::ZONE_COLD;
      if (t > 8'h50 + 8'({ws, 2'h0})) return btzm_pkg::ZONE_WARM;
      if (t <= 8'h28 + 8'({cs, 2'h0})) return btzm_pkg::ZONE_COOL;
      return btzm_pkg::ZONE_NORMAL;
   endfunction : ez
   // set temperature, wait out the two-stage latency, check zone, state, codes, flag
   task automatic zcheck(input logic [7:0] t);
      logic [2:0] z;
      logic f, m;
      z = ez(t);
      f = z == btzm_pkg::ZONE_HOT || z == btzm_pkg::ZONE_COLD;
      m = z == btzm_pkg::ZONE_WARM || z == btzm_pkg::ZONE_COOL;
      temp = t;
      cyc(3);
      chk("zone", zs, z);
      chk("fault", tf, f);
      chk("allowed", ok, !f);
      if (!f) begin
         chk("vcode", av, m ? mv : cve);
         chk("icode", aic, m ? mc : nc);
      end
      if (z != pz) begin
         chk("zirq", zirq, !zmask);
         zmask = 1'b0;
         zclr = 1'b1;
         #1 chk("zirq_unmask", zirq, 1'b1);
         cyc(1);
         zclr = 1'b0;
         cyc(1);
         chk("zirq_clr", zirq, 1'b0);
      end
      pz = z;
   endtask : zcheck
   // request stays 20; a clear together with a live violation must lose
   task automatic rcheck(input logic [5:0] r, input logic clr);
      logic bad;
      bad = r < req + 6'h08;
      cve = r < 6'h08 ? 6'h00 : (bad ? r - 6'h08 : req);
      rexp = (rexp && !clr) || bad;
      rail = r;
      rclr = clr;
      cyc(1);
      rclr = 1'b0;
      cyc(1);
      chk("cv", cv, cve);
      chk("rail_irq", rirq, rexp);
   endtask : rcheck
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report
   // a hang costs a mismatch; the whole run is under one thousand ns
   initial begin
      #20000;
      errors++;
      final_report();
   end
   initial begin
      cyc(6);
      chk("zone_rst", zs, btzm_pkg::ZONE_RESET);
      chk("cv_rst", cv, btzm_pkg::CV_RESET);
      rst_n = 1'b1;
      foreach (zt[i]) zcheck(zt[i]);
      // hot and cold trip selects at their boundaries, both sides
      for (int k = 0; k < 4; k++) begin
         {hs, ws, cs, ds} = {4{k[1:0]}};
         zcheck(8'h65 + 8'(k * 4));
         zcheck(8'h64 + 8'(k * 4));
         zcheck(8'h14 + 8'(k * 4));
         zcheck(8'h15 + 8'(k * 4));
      end
      {hs, ws, cs, ds} = 8'haa;
      $display("test zones done");
      zcheck(8'h3c);
      zcheck(8'h6e);
      prior = 3'h1;
      chk("resume", rs, 3'h6);
      chk("paused", tp, 1'b1);
      temp = 8'h3c;
      cyc(1);
      chk("fast_early", fr, 1'b0);
      chk("still_paused", tp, 1'b1);
      cyc(1);
      chk("restarts", {fr, tr}, 2'h3);
      chk("fault_gone", {tf, ok}, 2'h1);
      cyc(1);
      chk("pulse_end", {fr, tr, tp}, 3'h0);
      zmask = 1'b1;
      zcheck(8'h5a);
      mux = btzm_pkg::MUX_SEL_NTC_SENSE;
      zcheck(8'h6e);
      chk("resume_again", rs, 3'h1);
      mux = 4'h0;
      en = 1'b0;
      zcheck(8'h6e);
      en = 1'b1;
      zcheck(8'h3c);
      $display("test fault done");
      // exact margin, one code short, refused clear, tiny rail, recovery
      rcheck(6'h1c, 1'b0);
      rcheck(6'h1b, 1'b0);
      rcheck(6'h1b, 1'b1);
      zcheck(8'h3c);
      rcheck(6'h04, 1'b0);
      rcheck(6'h28, 1'b0);
      rcheck(6'h28, 1'b1);
      $display("test rail done");
      for (int b = 0; b < 16; b++) begin
         {en, vld} = b[1:0];
         mux = mt[b / 4];
         be = (en && vld) || mux == btzm_pkg::MUX_SEL_NTC_SENSE;
         be = be || mux == btzm_pkg::MUX_SEL_NTC_BIAS;
         cyc(1);
         chk("bias", bias, be);
      end
      $display("test bias done");
      final_report();
   end
endmodule : btzm_monitor_test
`default_nettype wire
